// *** acar_chan_decode.v ***
// registered decoder from channel code to input pair, gain and source kind
`timescale 1ns/1ns
`include "acar_defines.vh"

module acar_chan_decode (
	input wire ref_clk,
	input wire rstn,
	input wire [5:0] channel_code,
	output reg [2:0] pos_input,
	output reg [2:0] neg_input,
	output reg [2:0] source_kind,
	output reg gain_20x
);

	reg [2:0] next_pos;
	reg [2:0] next_neg;
	reg [2:0] next_kind;
	reg next_gain;
	reg [5:0] pair;

	// normal pair table, index is code bits 4..1; returns {positive, negative}
	function [5:0] pair_lookup;
		input [3:0] idx;
		begin
			case (idx)
				4'h4: pair_lookup = {3'h0, 3'h1};
				4'h5: pair_lookup = {3'h0, 3'h3};
				4'h6: pair_lookup = {3'h1, 3'h2};
				4'h7: pair_lookup = {3'h1, 3'h3};
				4'h8: pair_lookup = {3'h2, 3'h3};
				4'h9: pair_lookup = {3'h3, 3'h4};
				4'hA: pair_lookup = {3'h3, 3'h5};
				4'hB: pair_lookup = {3'h3, 3'h6};
				4'hC: pair_lookup = {3'h3, 3'h7};
				4'hD: pair_lookup = {3'h4, 3'h5};
				4'hE: pair_lookup = {3'h5, 3'h6};
				4'hF: pair_lookup = {3'h6, 3'h7};
				default: pair_lookup = {3'h0, 3'h0};
			endcase
		end
	endfunction

	always @*
	begin
		pair = pair_lookup(channel_code[4:1]);
		next_pos = channel_code[2:0];
		next_neg = `ACAR_INPUT_NONE;
		next_kind = `ACAR_KIND_SINGLE;
		next_gain = 1'b0;
		if (channel_code[4:3] != 2'h0)
		begin
			next_kind = `ACAR_KIND_DIFF;
			next_gain = channel_code[0];
			if (channel_code[5])
			begin
				next_pos = pair[2:0];
				next_neg = pair[5:3];
			end
			else
			begin
				next_pos = pair[5:3];
				next_neg = pair[2:0];
			end
		end
		else if (channel_code[5])
		begin
			case (channel_code[2:0])
				3'h0: next_kind = `ACAR_KIND_GROUND;
				3'h1: next_kind = `ACAR_KIND_BANDGAP;
				3'h2: next_kind = `ACAR_KIND_TEMP;
				3'h3:
				begin
					next_kind = `ACAR_KIND_OFFSET_CAL;
					next_pos = 3'h0;
					next_gain = 1'b1;
				end
				3'h4, 3'h5:
				begin
					next_kind = `ACAR_KIND_OFFSET_CAL;
					next_pos = 3'h3;
					next_gain = channel_code[0];
				end
				default:
				begin
					next_kind = `ACAR_KIND_OFFSET_CAL;
					next_pos = 3'h7;
					next_gain = channel_code[0];
				end
			endcase
			if (next_kind == `ACAR_KIND_OFFSET_CAL)
				next_neg = next_pos;
			else
				next_pos = `ACAR_INPUT_NONE;
		end
	end

	always @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pos_input <= 3'h0;
			neg_input <= 3'h0;
			source_kind <= `ACAR_KIND_SINGLE;
			gain_20x <= 1'b0;
		end
		else
		begin
			pos_input <= next_pos;
			neg_input <= next_neg;
			source_kind <= next_kind;
			gain_20x <= next_gain;
		end
	end

endmodule

// *** acar_ctrl.v ***
// converter control, trigger, completion flag and result registers
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ns
`include "acar_defines.vh"

module acar_ctrl #(
	parameter RESULT_WIDTH = 10,
	parameter TRIGGER_COUNT = 8
)(
	input wire ref_clk,
	input wire rstn,
	input wire [5:0] bus_addr,
	input wire [7:0] bus_wdata,
	input wire bus_wr,
	input wire bus_rd,
	output reg [7:0] bus_rdata,
	input wire [TRIGGER_COUNT-1:0] trigger_sources,
	input wire global_irq_enable,
	input wire irq_vector_ack,
	input wire [RESULT_WIDTH-1:0] analog_result,
	output wire irq_request,
	output wire converter_power,
	output wire conversion_active,
	output reg conversion_complete,
	output reg sample_hold,
	output wire converter_tick,
	output reg [1:0] reference_select,
	output wire [2:0] pos_input,
	output wire [2:0] neg_input,
	output wire [2:0] source_kind,
	output wire gain_20x,
	output wire bipolar_mode
);

	localparam ST_IDLE = 2'b01;
	localparam ST_CONV = 2'b10;

	reg [1:0] state;
	reg [5:0] channel_select;
	reg [1:0] reference_sw;
	reg [5:0] active_channel;
	reg converter_enable;
	reg conversion_start;
	reg auto_trigger_enable;
	reg conversion_done_flag;
	reg conversion_done_irq_enable;
	reg [2:0] converter_clock_divider;
	reg bipolar_bit;
	reg comparator_mux_bit;
	reg reserved5_bit;
	reg result_left_adjust;
	reg reserved3_bit;
	reg [2:0] trigger_source_select;
	reg [2:0] prev_trigger_select;
	reg prev_trigger_level;
	reg [RESULT_WIDTH-1:0] conversion_result_bits;
	reg result_locked;
	reg first_pending;
	reg [4:0] tick_count;
	reg [4:0] conv_length;
	reg [4:0] sample_length;

	wire wr_ctrl_a = bus_wr && (bus_addr == `ACAR_OFS_CTRL_A);
	wire wr_ctrl_b = bus_wr && (bus_addr == `ACAR_OFS_CTRL_B);
	wire wr_channel = bus_wr && (bus_addr == `ACAR_OFS_CHANNEL);
	wire rd_low = bus_rd && (bus_addr == `ACAR_OFS_RESULT_LOW);
	wire rd_high = bus_rd && (bus_addr == `ACAR_OFS_RESULT_HIGH);

	wire next_enable = wr_ctrl_a ? bus_wdata[`ACAR_CA_ENABLE] : converter_enable;
	wire [5:0] next_channel = wr_channel ? bus_wdata[`ACAR_CH_MUX_HI:`ACAR_CH_MUX_LO] :
		channel_select;
	wire [1:0] next_reference = wr_channel ? bus_wdata[`ACAR_CH_REF_HI:`ACAR_CH_REF_LO] :
		reference_sw;

	wire sw_start = wr_ctrl_a && bus_wdata[`ACAR_CA_START] && bus_wdata[`ACAR_CA_ENABLE];
	wire trigger_level = (trigger_source_select == `ACAR_TRIG_FREE_RUN) ?
		conversion_done_flag : trigger_sources[trigger_source_select];
	wire trigger_rise = trigger_level && !prev_trigger_level;
	wire to_free_run = (trigger_source_select == `ACAR_TRIG_FREE_RUN) &&
		(prev_trigger_select != `ACAR_TRIG_FREE_RUN);
	wire trigger_event = auto_trigger_enable && trigger_rise && !to_free_run;
	wire start_now = (state == ST_IDLE) && next_enable && (sw_start || trigger_event);
	wire tick;
	wire finishing = (state == ST_CONV) && tick && (tick_count == conv_length - 1'b1);

	wire [7:0] result_high_byte = result_left_adjust ?
		conversion_result_bits[9:2] : {6'h00, conversion_result_bits[9:8]};
	wire [7:0] result_low_byte = result_left_adjust ?
		{conversion_result_bits[1:0], 6'h00} : conversion_result_bits[7:0];
	wire [7:0] control_status_a = {converter_enable, conversion_start, auto_trigger_enable,
		conversion_done_flag, conversion_done_irq_enable, converter_clock_divider};
	wire [7:0] control_status_b = {bipolar_bit, comparator_mux_bit, reserved5_bit,
		result_left_adjust, reserved3_bit, trigger_source_select};

	assign irq_request = conversion_done_flag && conversion_done_irq_enable &&
		global_irq_enable;
	assign converter_power = converter_enable;
	assign conversion_active = (state == ST_CONV);
	assign converter_tick = tick;
	assign bipolar_mode = bipolar_bit;

	acar_prescaler #(
		.COUNT_WIDTH(7)
	) u_prescaler (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.run(converter_enable),
		.divider_code(converter_clock_divider),
		.tick(tick)
	);

	acar_chan_decode u_decode (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.channel_code(active_channel),
		.pos_input(pos_input),
		.neg_input(neg_input),
		.source_kind(source_kind),
		.gain_20x(gain_20x)
	);

	// software writable fields
	always @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			channel_select <= 6'h00;
			reference_sw <= 2'h0;
			converter_enable <= 1'b0;
			auto_trigger_enable <= 1'b0;
			conversion_done_irq_enable <= 1'b0;
			converter_clock_divider <= 3'h0;
			bipolar_bit <= 1'b0;
			comparator_mux_bit <= 1'b0;
			reserved5_bit <= 1'b0;
			result_left_adjust <= 1'b0;
			reserved3_bit <= 1'b0;
			trigger_source_select <= 3'h0;
		end
		else
		begin
			channel_select <= next_channel;
			reference_sw <= next_reference;
			if (wr_ctrl_a)
			begin
				converter_enable <= bus_wdata[`ACAR_CA_ENABLE];
				auto_trigger_enable <= bus_wdata[`ACAR_CA_AUTO];
				conversion_done_irq_enable <= bus_wdata[`ACAR_CA_IRQ_EN];
				converter_clock_divider <= bus_wdata[`ACAR_CA_DIV_HI:`ACAR_CA_DIV_LO];
			end
			if (wr_ctrl_b)
			begin
				bipolar_bit <= bus_wdata[`ACAR_CB_BIPOLAR];
				comparator_mux_bit <= bus_wdata[`ACAR_CB_CMP_MUX];
				reserved5_bit <= bus_wdata[`ACAR_CB_RSVD5];
				result_left_adjust <= bus_wdata[`ACAR_CB_LEFT];
				reserved3_bit <= bus_wdata[`ACAR_CB_RSVD3];
				trigger_source_select <= bus_wdata[`ACAR_CB_TRIG_HI:`ACAR_CB_TRIG_LO];
			end
		end
	end

	// conversion sequencer
	always @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state <= ST_IDLE;
			conversion_start <= 1'b0;
			first_pending <= 1'b1;
			tick_count <= 5'h00;
			conv_length <= `ACAR_NORMAL_CONV_TICKS;
			sample_length <= `ACAR_NORMAL_SAMPLE_TICKS;
			sample_hold <= 1'b0;
			conversion_complete <= 1'b0;
		end
		else if (!next_enable)
		begin
			state <= ST_IDLE;
			conversion_start <= 1'b0;
			first_pending <= 1'b1;
			tick_count <= 5'h00;
			sample_hold <= 1'b0;
			conversion_complete <= 1'b0;
		end
		else
		begin
			conversion_complete <= 1'b0;
			case (state)
				ST_IDLE:
				begin
					if (start_now)
					begin
						state <= ST_CONV;
						conversion_start <= 1'b1;
						first_pending <= 1'b0;
						tick_count <= 5'h00;
						sample_hold <= 1'b1;
						if (first_pending)
						begin
							conv_length <= `ACAR_FIRST_CONV_TICKS;
							sample_length <= `ACAR_FIRST_SAMPLE_TICKS;
						end
						else
						begin
							conv_length <= `ACAR_NORMAL_CONV_TICKS;
							sample_length <= `ACAR_NORMAL_SAMPLE_TICKS;
						end
					end
				end
				ST_CONV:
				begin
					if (finishing)
					begin
						state <= ST_IDLE;
						conversion_start <= 1'b0;
						conversion_complete <= 1'b1;
						tick_count <= 5'h00;
					end
					else if (tick)
					begin
						tick_count <= tick_count + 1'b1;
						if (tick_count == sample_length - 1'b1)
							sample_hold <= 1'b0;
					end
				end
				default:
				begin
					state <= ST_IDLE;
					conversion_start <= 1'b0;
				end
			endcase
		end
	end

	// channel and reference seen by the converter only change between conversions
	always @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			active_channel <= 6'h00;
			reference_select <= 2'h0;
		end
		else if (state == ST_IDLE || finishing)
		begin
			active_channel <= next_channel;
			reference_select <= next_reference;
		end
	end

	// result capture, read lock and done flag
	always @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			conversion_result_bits <= {RESULT_WIDTH{1'b0}};
			result_locked <= 1'b0;
			conversion_done_flag <= 1'b0;
		end
		else
		begin
			if (finishing && !result_locked)
				conversion_result_bits <= analog_result;
			if (rd_low)
				result_locked <= 1'b1;
			else if (rd_high)
				result_locked <= 1'b0;
			if (finishing)
				conversion_done_flag <= 1'b1;
			else if ((wr_ctrl_a && bus_wdata[`ACAR_CA_DONE]) || irq_vector_ack)
				conversion_done_flag <= 1'b0;
		end
	end

	// trigger edge history
	always @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			prev_trigger_level <= 1'b0;
			prev_trigger_select <= 3'h0;
		end
		else
		begin
			prev_trigger_level <= trigger_level;
			prev_trigger_select <= trigger_source_select;
		end
	end

	// read data, valid only in the cycle after the read strobe
	always @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			bus_rdata <= `ACAR_RESET_BYTE;
		else if (bus_rd)
		begin
			case (bus_addr)
				`ACAR_OFS_CHANNEL: bus_rdata <= {reference_sw, channel_select};
				`ACAR_OFS_CTRL_A: bus_rdata <= control_status_a;
				`ACAR_OFS_RESULT_HIGH: bus_rdata <= result_high_byte;
				`ACAR_OFS_RESULT_LOW: bus_rdata <= result_low_byte;
				`ACAR_OFS_CTRL_B: bus_rdata <= control_status_b;
				default: bus_rdata <= `ACAR_RESET_BYTE;
			endcase
		end
		else
			bus_rdata <= `ACAR_RESET_BYTE;
	end

endmodule

// *** acar_ctrl_checker.sv ***
// assertion checker for the converter control block
`timescale 1ns/1ns
module acar_ctrl_checker (
	input wire ref_clk,
	input wire rstn,
	input wire global_irq_enable,
	input wire irq_vector_ack,
	input wire irq_request,
	input wire converter_power,
	input wire conversion_active,
	input wire conversion_complete,
	input wire sample_hold,
	input wire converter_tick
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);
	property p_irq_global;
		irq_request |-> global_irq_enable;
	endproperty
	a_irq_global: assert property (p_irq_global) else $error("irq without global");
	property p_ack_clear;
		irq_vector_ack && !conversion_active |=> !irq_request;
	endproperty
	a_ack_clear: assert property (p_ack_clear) else $error("ack left irq up");
	property p_done;
		conversion_complete |-> !conversion_active && $past(conversion_active);
	endproperty
	a_done: assert property (p_done) else $error("completion not after a run");
	property p_done_pulse;
		conversion_complete |=> !conversion_complete;
	endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("completion too long");
	property p_power_off;
		!converter_power |-> !conversion_active;
	endproperty
	a_power_off: assert property (p_power_off) else $error("running while off");
	property p_tick_off;
		!converter_power |=> !converter_tick;
	endproperty
	a_tick_off: assert property (p_tick_off) else $error("tick while off");
	property p_tick_gap;
		$rose(converter_tick) |=> !converter_tick;
	endproperty
	a_tick_gap: assert property (p_tick_gap) else $error("ticks too close");
	property p_sample;
		$rose(conversion_active) |-> sample_hold;
	endproperty
	a_sample: assert property (p_sample) else $error("no sample at start");
endmodule

bind acar_ctrl acar_ctrl_checker chk (.ref_clk, .rstn, .global_irq_enable, .irq_vector_ack,
	.irq_request, .converter_power, .conversion_active, .conversion_complete, .sample_hold,
	.converter_tick);

// *** acar_defines.vh ***
// register offsets, field positions, reset values and counts for the converter control
`ifndef ACAR_DEFINES_VH
`define ACAR_DEFINES_VH

`define ACAR_ADDR_WIDTH 6
`define ACAR_OFS_CTRL_B 6'h03
`define ACAR_OFS_RESULT_LOW 6'h04
`define ACAR_OFS_RESULT_HIGH 6'h05
`define ACAR_OFS_CTRL_A 6'h06
`define ACAR_OFS_CHANNEL 6'h07

`define ACAR_RESET_BYTE 8'h00

`define ACAR_CA_ENABLE 7
`define ACAR_CA_START 6
`define ACAR_CA_AUTO 5
`define ACAR_CA_DONE 4
`define ACAR_CA_IRQ_EN 3
`define ACAR_CA_DIV_HI 2
`define ACAR_CA_DIV_LO 0

`define ACAR_CB_BIPOLAR 7
`define ACAR_CB_CMP_MUX 6
`define ACAR_CB_RSVD5 5
`define ACAR_CB_LEFT 4
`define ACAR_CB_RSVD3 3
`define ACAR_CB_TRIG_HI 2
`define ACAR_CB_TRIG_LO 0

`define ACAR_CH_REF_HI 7
`define ACAR_CH_REF_LO 6
`define ACAR_CH_MUX_HI 5
`define ACAR_CH_MUX_LO 0

`define ACAR_TRIG_FREE_RUN 3'h0

`define ACAR_FIRST_CONV_TICKS 5'h19
`define ACAR_NORMAL_CONV_TICKS 5'h0D
`define ACAR_FIRST_SAMPLE_TICKS 5'h0E
`define ACAR_NORMAL_SAMPLE_TICKS 5'h02

`define ACAR_KIND_SINGLE 3'h0
`define ACAR_KIND_DIFF 3'h1
`define ACAR_KIND_OFFSET_CAL 3'h2
`define ACAR_KIND_GROUND 3'h3
`define ACAR_KIND_BANDGAP 3'h4
`define ACAR_KIND_TEMP 3'h5

`define ACAR_INPUT_NONE 3'h0

`endif

// *** acar_prescaler.v ***
// converter clock prescaler producing one tick per division period
`timescale 1ns/1ns
`include "acar_defines.vh"

module acar_prescaler #(
	parameter COUNT_WIDTH = 7
)(
	input wire ref_clk,
	input wire rstn,
	input wire run,
	input wire [2:0] divider_code,
	output reg tick
);

	reg [COUNT_WIDTH-1:0] count;

	function [COUNT_WIDTH-1:0] divide_limit;
		input [2:0] code;
		begin
			if (code < 3'h2)
				divide_limit = {{(COUNT_WIDTH-1){1'b0}}, 1'b1};
			else
				divide_limit = (({{(COUNT_WIDTH-1){1'b0}}, 1'b1}) << code) - 1'b1;
		end
	endfunction

	always @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			count <= {COUNT_WIDTH{1'b0}};
			tick <= 1'b0;
		end
		else if (!run)
		begin
			count <= {COUNT_WIDTH{1'b0}};
			tick <= 1'b0;
		end
		else if (count >= divide_limit(divider_code))
		begin
			count <= {COUNT_WIDTH{1'b0}};
			tick <= 1'b1;
		end
		else
		begin
			count <= count + 1'b1;
			tick <= 1'b0;
		end
	end

endmodule

// *** test_acar_ctrl.sv ***
// self-checking bench for the converter control block
`timescale 1ns/1ns
module test_acar_ctrl;
	reg ref_clk = 1'b0;
	reg rstn = 1'b0;
	reg [5:0] bus_addr = 6'h00;
	reg [7:0] bus_wdata = 8'h00;
	reg bus_wr = 1'b0;
	reg bus_rd = 1'b0;
	reg [7:0] trigger_sources = 8'h00;
	reg global_irq_enable = 1'b0;
	reg irq_vector_ack = 1'b0;
	reg [9:0] analog_result = 10'h000;
	wire [7:0] bus_rdata;
	wire [1:0] reference_select;
	wire [2:0] pos_input, neg_input, source_kind;
	wire irq_request, converter_power, conversion_active, conversion_complete;
	wire sample_hold, converter_tick, gain_20x, bipolar_mode;
	integer errors = 0;
	integer checked = 0;
	integer ticks = 0;
	integer t, c, i;
	reg [15:0] tab [0:7];

	always #5 ref_clk = ~ref_clk;

	acar_ctrl uut (.ref_clk, .rstn, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata,
		.trigger_sources, .global_irq_enable, .irq_vector_ack, .analog_result, .irq_request,
		.converter_power, .conversion_active, .conversion_complete, .sample_hold,
		.converter_tick, .reference_select, .pos_input, .neg_input, .source_kind, .gain_20x,
		.bipolar_mode);

	// ticks seen during the running conversion
	always @(posedge ref_clk)
		if (conversion_active !== 1'b1)
			ticks <= 0;
		else if (converter_tick === 1'b1)
			ticks <= ticks + 1;

	task stop_test;
	begin
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	end
	endtask

	task cmp(input [15:0] got, input [15:0] exp);
	begin
		checked = checked + 1;
		if (got !== exp)
		begin
			errors = errors + 1;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	end
	endtask

	task wr(input [5:0] a, input [7:0] v);
	begin
		bus_addr <= a;
		bus_wdata <= v;
		bus_wr <= 1'b1;
		@(posedge ref_clk);
		bus_wr <= 1'b0;
	end
	endtask

	// read data stands only in the cycle after the strobe
	task rc(input [5:0] a, input [7:0] exp);
	begin
		bus_addr <= a;
		bus_rd <= 1'b1;
		@(posedge ref_clk);
		bus_rd <= 1'b0;
		#1;
		cmp({8'h00, bus_rdata}, {8'h00, exp});
		@(posedge ref_clk);
	end
	endtask

	// wait for the completion pulse, t gets the ticks used
	task conv;
	begin
		c = 0;
		while (c == 0 || (conversion_complete !== 1'b1 && c < 4000))
		begin
			@(posedge ref_clk);
			#1;
			c = c + 1;
		end
		t = ticks;
		if (c >= 4000)
		begin
			errors = errors + 1;
			$display("mismatch at %0t: no completion", $time);
		end
		@(posedge ref_clk);
	end
	endtask

	// cycles up to the next prescaler tick, 300 if none
	task tk;
	begin
		c = 0;
		while (c == 0 || (converter_tick !== 1'b1 && c < 300))
		begin
			@(posedge ref_clk);
			#1;
			c = c + 1;
		end
	end
	endtask

	task t_decode;
	begin
		tab[0] = 16'h2012;
		tab[1] = 16'h2413;
		tab[2] = 16'hA082;
		tab[3] = 16'h8C05;
		tab[4] = 16'h91B4;
		tab[5] = 16'h9BF4;
		tab[6] = 16'hFFE3;
		tab[7] = 16'h65F3;
		for (i = 0; i < 8; i = i + 1)
		begin
			wr(6'h07, {2'b00, tab[i][15:10]});
			repeat (2) @(posedge ref_clk);
			#1;
			cmp({6'h00, pos_input, neg_input, source_kind, gain_20x}, {6'h00, tab[i][9:0]});
			@(posedge ref_clk);
		end
		$display("test decode done");
	end
	endtask

	task t_first;
	begin
		rc(6'h04, 8'h00);
		rc(6'h05, 8'h00);
		rc(6'h06, 8'h00);
		rc(6'h3F, 8'h00);
		analog_result <= 10'h2A5;
		wr(6'h06, 8'hC0);
		rc(6'h06, 8'hC0);
		#1;
		cmp({15'h0000, sample_hold}, 16'h0001);
		conv;
		cmp(t[15:0], 16'h0019);
		rc(6'h06, 8'h90);
		rc(6'h04, 8'hA5);
		rc(6'h05, 8'h02);
		wr(6'h03, 8'hB0);
		rc(6'h03, 8'hB0);
		cmp({15'h0000, bipolar_mode}, 16'h0001);
		rc(6'h04, 8'h40);
		rc(6'h05, 8'hA9);
		wr(6'h03, 8'h00);
		analog_result <= 10'h155;
		@(posedge ref_clk);
		wr(6'h06, 8'hD0);
		@(posedge ref_clk);
		wr(6'h07, 8'h68);
		#1;
		cmp({11'h000, reference_select, pos_input}, 16'h0003);
		@(posedge ref_clk);
		conv;
		cmp(t[15:0], 16'h000D);
		#1;
		cmp({11'h000, reference_select, pos_input}, 16'h0009);
		@(posedge ref_clk);
		rc(6'h07, 8'h68);
		$display("test first done");
	end
	endtask

	task t_lock;
	begin
		rc(6'h04, 8'h55);
		analog_result <= 10'h3FF;
		wr(6'h06, 8'hD0);
		conv;
		rc(6'h05, 8'h01);
		wr(6'h06, 8'hD0);
		conv;
		rc(6'h04, 8'hFF);
		rc(6'h05, 8'h03);
		$display("test lock done");
	end
	endtask

	task t_flag;
	begin
		global_irq_enable <= 1'b1;
		wr(6'h06, 8'h88);
		#1;
		cmp({15'h0000, irq_request}, 16'h0001);
		@(posedge ref_clk);
		global_irq_enable <= 1'b0;
		@(posedge ref_clk);
		#1;
		cmp({15'h0000, irq_request}, 16'h0000);
		@(posedge ref_clk);
		global_irq_enable <= 1'b1;
		irq_vector_ack <= 1'b1;
		@(posedge ref_clk);
		irq_vector_ack <= 1'b0;
		rc(6'h06, 8'h88);
		wr(6'h06, 8'hC8);
		conv;
		wr(6'h06, 8'h98);
		rc(6'h06, 8'h88);
		global_irq_enable <= 1'b0;
		$display("test flag done");
	end
	endtask

	task t_div;
	begin
		for (i = 0; i < 8; i = i + 1)
		begin
			wr(6'h06, 8'h80 | i[7:0]);
			tk;
			tk;
			cmp(c[15:0], (i < 2) ? 16'h0002 : (16'h0001 << i));
			@(posedge ref_clk);
		end
		wr(6'h06, 8'h00);
		tk;
		cmp(c[15:0], 16'h012C);
		@(posedge ref_clk);
		$display("test divider done");
	end
	endtask

	task t_abort;
	begin
		wr(6'h06, 8'hC0);
		repeat (10) @(posedge ref_clk);
		wr(6'h06, 8'h00);
		#1;
		cmp({14'h0000, converter_power, conversion_active}, 16'h0000);
		@(posedge ref_clk);
		rc(6'h06, 8'h00);
		wr(6'h06, 8'hC0);
		conv;
		cmp(t[15:0], 16'h0019);
		$display("test abort done");
	end
	endtask

	task t_trig;
	begin
		wr(6'h06, 8'hB0);
		@(posedge ref_clk);
		wr(6'h03, 8'h02);
		trigger_sources <= 8'h04;
		conv;
		cmp(t[15:0], 16'h000D);
		trigger_sources <= 8'h08;
		@(posedge ref_clk);
		wr(6'h03, 8'h03);
		conv;
		cmp(t[15:0], 16'h000D);
		trigger_sources <= 8'h00;
		wr(6'h03, 8'h00);
		repeat (4) @(posedge ref_clk);
		#1;
		cmp({15'h0000, conversion_active}, 16'h0000);
		@(posedge ref_clk);
		wr(6'h06, 8'hF0);
		conv;
		conv;
		cmp(t[15:0], 16'h000D);
		wr(6'h06, 8'h00);
		$display("test trigger done");
	end
	endtask

	initial
	begin
		#200000;
		errors = errors + 1;
		stop_test;
	end

	initial
	begin
		repeat (5) @(posedge ref_clk);
		rstn <= 1'b1;
		@(posedge ref_clk);
		t_decode;
		t_first;
		t_lock;
		t_flag;
		t_div;
		t_abort;
		t_trig;
		stop_test;
	end
endmodule
